/* verilog/retimer_link_control_regs.sv */
// configuration register bank 0x0A..0x0C with staged lane settings and ratio snoop
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - placement bit picks equalizer centre source/sink
// - gating bit blocks hot-plug forwarding
// - equalizer mode fixed/adaptive, strap locks writes
// - equalizer enable bit, resets enabled
// - aux bridge enable, default on
// - lane settings staged until commit write
// - settings apply directly while link idle
// - function mode field selects redriver/retimer
// - edge rate field, strap locks writes
// - protocol select HDMI/DVI, strap locks writes
// - termination field mirrors strap pin in strap mode, loads it once after reset
// - ratio flag follows snooped sideband write
// - long hot-plug low clears ratio flag
// - ratio flag selects tenth or fortieth
// - training disable bit, default enabled
// - training disable forces fortieth ratio
// - data swing field steps
// - clock swing field steps, 110/111 equal
// - post-cursor de-emphasis field
// - reserved bits read zero, ignore writes
module retimer_link_control_regs
  import link_ctrl_pkg::*;
#(
  parameter int HPD_LOW_COUNT = link_ctrl_pkg::HPD_LOW_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       strap_config,
  input  wire logic [1:0] strap_termination,
  input  wire logic       output_enable_in,
  input  wire logic       sink_hot_plug_in,
  output logic            source_hot_plug_out,
  input  wire logic       snoop_wr_valid,
  input  wire logic [6:0] snoop_slave,
  input  wire logic [7:0] snoop_offset,
  input  wire logic [7:0] snoop_data,
  output logic            app_sink_centre,
  output logic            aux_ddc_bridge_on,
  output logic [1:0]      function_mode_select,
  output logic            dvi_select,
  output logic            ddc_training_disable,
  output logic            link_clock_ratio_flag,
  output logic            lane_equalizer_adaptive,
  output logic            lane_equalizer_on,
  output logic [1:0]      lane_edge_rate,
  output logic [1:0]      lane_termination,
  output logic [2:0]      lane_data_swing,
  output logic [2:0]      lane_clock_swing,
  output logic [1:0]      lane_deemphasis,
  input  wire logic       forced_power_down
);
  import link_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]  eq_mode_q, eq_mode_d;
  logic [7:0]  proto_q, proto_d;
  logic [7:0]  swing_q, swing_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        hp_out_q, hp_out_d;
  logic        ratio_q, ratio_d;
  logic [31:0] hpd_cnt_q, hpd_cnt_d;
  logic        strap_seen_q, strap_seen_d;

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // helpers shared by the write and commit decoders

  // write strobe aimed at one register offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction : wr_hit

  // register writes; strap-locked bits drop out of the mask in pin-strap mode

  always_comb begin
    logic [7:0] m_eq;
    logic [7:0] m_pr;
    m_eq = LINK_EQ_MODE_WMASK;
    m_pr = OUTPUT_PROTOCOL_WMASK;
    if (!strap_config) begin
      m_eq = m_eq & ~LINK_EQ_STRAP_MASK;
      m_pr = m_pr & ~OUTPUT_PROTO_STRAP_MASK;
    end
    eq_mode_d    = eq_mode_q;
    proto_d      = proto_q;
    swing_d      = swing_q;
    if (wr_hit(reg_wr, reg_addr, LINK_EQ_MODE_OFFSET)) begin
      eq_mode_d = merge(eq_mode_q, reg_wdata, m_eq);
    end
    if (wr_hit(reg_wr, reg_addr, OUTPUT_PROTOCOL_OFFSET)) begin
      proto_d = merge(proto_q, reg_wdata, m_pr);
    end
    if (wr_hit(reg_wr, reg_addr, OUTPUT_SWING_OFFSET)) begin
      swing_d = merge(swing_q, reg_wdata, OUTPUT_SWING_WMASK);
    end
    // termination follows its strap pin while straps configure the part
    if (!strap_config || !strap_seen_q) begin
      proto_d[TERM_LSB +: 2] = strap_termination;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eq_mode_q    <= LINK_EQ_MODE_RESET;
      proto_q      <= OUTPUT_PROTOCOL_RESET;
      swing_q      <= OUTPUT_SWING_RESET;
    end else if (clk_en) begin
      eq_mode_q    <= eq_mode_d;
      proto_q      <= proto_d;
      swing_q      <= swing_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap-seen marker: termination takes the strap pin once after reset
  always_comb begin
    strap_seen_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_seen_q <= 1'b0;
    end else if (clk_en) begin
      strap_seen_q <= strap_seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hot-plug low timer: counts consecutive low cycles, saturates past the limit
  logic hpd_expired;

  always_comb begin
    hpd_cnt_d = hpd_cnt_q;
    if (sink_hot_plug_in) begin
      hpd_cnt_d = 32'h0000_0000;
    end else if (hpd_cnt_q <= HPD_LOW_COUNT) begin
      hpd_cnt_d = hpd_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hpd_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      hpd_cnt_q <= hpd_cnt_d;
    end
  end

  // a low that has lasted the full count clears the ratio flag;
  // the flag stays cleared for as long as the pin stays low and training disable is clear
  assign hpd_expired = !sink_hot_plug_in && (hpd_cnt_q >= HPD_LOW_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // ratio flag: sideband snoop, forced by training disable, cleared by long hot-plug low
  logic snoop_hit;
  logic ratio_forced;

  assign snoop_hit    = snoop_wr_valid && snoop_slave == SCDC_SLAVE_ADDR
                        && snoop_offset == SCDC_RATIO_OFFSET;
  assign ratio_forced = proto_q[TRAIN_DIS_BIT];

  // forcing beats timeout beats snoop, so a forced link never falls back to 1/10
  always_comb begin
    ratio_d = ratio_q;
    if (snoop_hit) begin
      ratio_d = snoop_data[SCDC_RATIO_BIT];
    end
    if (hpd_expired) begin
      ratio_d = 1'b0;
    end
    if (ratio_forced) begin
      ratio_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratio_q <= 1'b0;
    end else if (clk_en) begin
      ratio_q <= ratio_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staged lane settings
  logic       commit;
  logic       link_idle;
  logic       lane_adapt_q, lane_adapt_d;
  logic       lane_eq_on_q, lane_eq_on_d;
  logic [1:0] lane_edge_q, lane_edge_d;
  logic [1:0] lane_term_q, lane_term_d;
  logic [2:0] lane_dsw_q, lane_dsw_d;
  logic [2:0] lane_csw_q, lane_csw_d;
  logic [1:0] lane_de_q, lane_de_d;

  logic       lane_load;

  // commit is a strobe only: nothing of it is stored, so it always reads back 0
  assign commit    = wr_hit(reg_wr, reg_addr, LINK_EQ_MODE_OFFSET) && reg_wdata[COMMIT_BIT];
  assign link_idle = !output_enable_in || !sink_hot_plug_in || forced_power_down;
  // while the link is idle the lanes track the registers with no commit needed
  assign lane_load = commit || link_idle;

  always_comb begin
    lane_adapt_d = lane_adapt_q;
    lane_eq_on_d = lane_eq_on_q;
    lane_edge_d  = lane_edge_q;
    lane_term_d  = lane_term_q;
    lane_dsw_d   = lane_dsw_q;
    lane_csw_d   = lane_csw_q;
    lane_de_d    = lane_de_q;
    if (lane_load) begin
      lane_adapt_d = eq_mode_q[EQ_ADAPT_BIT];
      lane_eq_on_d = eq_mode_q[EQ_ON_BIT];
      lane_edge_d  = proto_q[EDGE_RATE_LSB +: 2];
      lane_term_d  = proto_q[TERM_LSB +: 2];
      lane_dsw_d   = swing_q[DATA_SWING_LSB +: 3];
      lane_csw_d   = swing_q[CLK_SWING_LSB +: 3];
      lane_de_d    = swing_q[DEEMPH_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lane_adapt_q <= LINK_EQ_MODE_RESET[EQ_ADAPT_BIT];
      lane_eq_on_q <= LINK_EQ_MODE_RESET[EQ_ON_BIT];
      lane_edge_q  <= OUTPUT_PROTOCOL_RESET[EDGE_RATE_LSB +: 2];
      lane_term_q  <= OUTPUT_PROTOCOL_RESET[TERM_LSB +: 2];
      lane_dsw_q   <= OUTPUT_SWING_RESET[DATA_SWING_LSB +: 3];
      lane_csw_q   <= OUTPUT_SWING_RESET[CLK_SWING_LSB +: 3];
      lane_de_q    <= OUTPUT_SWING_RESET[DEEMPH_LSB +: 2];
    end else if (clk_en) begin
      lane_adapt_q <= lane_adapt_d;
      lane_eq_on_q <= lane_eq_on_d;
      lane_edge_q  <= lane_edge_d;
      lane_term_q  <= lane_term_d;
      lane_dsw_q   <= lane_dsw_d;
      lane_csw_q   <= lane_csw_d;
      lane_de_q    <= lane_de_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: registered, holds the last value read
  function automatic logic [7:0] read_back(input logic [7:0] addr,
                                           input logic [7:0] eq_v,
                                           input logic [7:0] proto_v,
                                           input logic [7:0] swing_v,
                                           input logic       ratio_v);
    logic [7:0] word;
    word = 8'h00;
    case (addr)
      LINK_EQ_MODE_OFFSET: begin
        word = eq_v & LINK_EQ_MODE_WMASK;
      end
      OUTPUT_PROTOCOL_OFFSET: begin
        word            = proto_v & OUTPUT_PROTOCOL_WMASK;
        word[RATIO_BIT] = ratio_v;
      end
      OUTPUT_SWING_OFFSET: begin
        word = swing_v;
      end
      default: begin
        word = 8'h00;
      end
    endcase
    read_back = word;
  endfunction : read_back

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = read_back(reg_addr, eq_mode_q, proto_q, swing_q, ratio_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hot-plug forwarding: one flop of delay, held low while the gate bit is set
  always_comb begin
    hp_out_d = sink_hot_plug_in && !eq_mode_q[HP_BLOCK_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hp_out_q <= 1'b0;
    end else if (clk_en) begin
      hp_out_q <= hp_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop

  assign reg_rdata               = rdata_q;
  assign source_hot_plug_out     = hp_out_q;
  assign app_sink_centre         = eq_mode_q[APP_SINK_BIT];
  assign aux_ddc_bridge_on       = eq_mode_q[AUX_ON_BIT];
  assign function_mode_select    = eq_mode_q[FUNC_MODE_LSB +: 2];
  assign dvi_select              = proto_q[DVI_SEL_BIT];
  assign ddc_training_disable    = proto_q[TRAIN_DIS_BIT];
  assign link_clock_ratio_flag   = ratio_q;
  assign lane_equalizer_adaptive = lane_adapt_q;
  assign lane_equalizer_on       = lane_eq_on_q;
  assign lane_edge_rate          = lane_edge_q;
  assign lane_termination        = lane_term_q;
  assign lane_data_swing         = lane_dsw_q;
  assign lane_clock_swing        = lane_csw_q;
  assign lane_deemphasis         = lane_de_q;

endmodule : retimer_link_control_regs

`default_nettype wire

/* verilog/link_ctrl_pkg.sv */
// register map, field positions, reset values and timing counts of the link control bank
package link_ctrl_pkg;

  localparam logic [7:0] LINK_EQ_MODE_OFFSET     = 8'h0A;
  localparam logic [7:0] OUTPUT_PROTOCOL_OFFSET  = 8'h0B;
  localparam logic [7:0] OUTPUT_SWING_OFFSET     = 8'h0C;

  // 0x0A field positions
  localparam int APP_SINK_BIT     = 7;
  localparam int HP_BLOCK_BIT     = 6;
  localparam int EQ_ADAPT_BIT     = 5;
  localparam int EQ_ON_BIT        = 4;
  localparam int AUX_ON_BIT       = 3;
  localparam int COMMIT_BIT       = 2;
  localparam int FUNC_MODE_LSB    = 0;

  // 0x0B field positions
  localparam int EDGE_RATE_LSB    = 6;
  localparam int DVI_SEL_BIT      = 5;
  localparam int TERM_LSB         = 3;
  localparam int RATIO_BIT        = 1;
  localparam int TRAIN_DIS_BIT    = 0;

  // 0x0C field positions
  localparam int DATA_SWING_LSB   = 5;
  localparam int CLK_SWING_LSB    = 2;
  localparam int DEEMPH_LSB       = 0;

  // reset values
  localparam logic [7:0] LINK_EQ_MODE_RESET    = 8'h39;
  localparam logic [7:0] OUTPUT_PROTOCOL_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_SWING_RESET    = 8'h00;

  // writable masks, reserved bits excluded
  localparam logic [7:0] LINK_EQ_MODE_WMASK    = 8'hFB;
  localparam logic [7:0] OUTPUT_PROTOCOL_WMASK = 8'hF9;
  localparam logic [7:0] OUTPUT_SWING_WMASK    = 8'hFF;
  // bits frozen while configuration comes from straps
  localparam logic [7:0] LINK_EQ_STRAP_MASK    = 8'h20;
  localparam logic [7:0] OUTPUT_PROTO_STRAP_MASK = 8'hF8;

  // function mode codes
  localparam logic [1:0] MODE_REDRIVER  = 2'b00;
  localparam logic [1:0] MODE_AUTO_XOVR = 2'b01;
  localparam logic [1:0] MODE_AUTO_RT20 = 2'b10;
  localparam logic [1:0] MODE_RETIMER   = 2'b11;

  localparam logic [1:0] TERM_RESERVED  = 2'b10;

  // sideband snoop target
  localparam logic [6:0] SCDC_SLAVE_ADDR = 7'h54;
  localparam logic [7:0] SCDC_RATIO_OFFSET = 8'h20;
  localparam int         SCDC_RATIO_BIT  = 1;

  // hot-plug low time that clears the ratio flag
  localparam int CLK_MHZ          = 200;
  localparam int HPD_LOW_TIME_US  = 2000;
  localparam int HPD_LOW_CYCLES   = HPD_LOW_TIME_US * CLK_MHZ;

endpackage : link_ctrl_pkg

/* testbench/link_regs_assertions.sv */
// port assertions for the link control register bank
`timescale 1ns/1ps
`default_nettype none
module link_regs_checker #(
  parameter int HPD_LOW_COUNT = 20
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       output_enable_in,
  input wire logic       sink_hot_plug_in,
  input wire logic       source_hot_plug_out,
  input wire logic       forced_power_down,
  input wire logic       snoop_wr_valid,
  input wire logic [6:0] snoop_slave,
  input wire logic [7:0] snoop_offset,
  input wire logic [7:0] snoop_data,
  input wire logic       ddc_training_disable,
  input wire logic       link_clock_ratio_flag,
  input wire logic [1:0] lane_deemphasis
);
  int   low_cnt_q;
  int   low_cnt_d;
  logic idle;
  logic commit;
  assign idle   = !output_enable_in || !sink_hot_plug_in || forced_power_down;
  assign commit = reg_wr && reg_addr == 8'h0A && reg_wdata[2];
  // consecutive hot-plug low cycles, saturating
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (clk_en && sink_hot_plug_in) low_cnt_d = 0;
    else if (clk_en && low_cnt_q < HPD_LOW_COUNT + 9) low_cnt_d = low_cnt_q + 1;
  end
  always_ff @(posedge clk) low_cnt_q <= rst_n ? low_cnt_d : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_snoop_hit;
    clk_en && snoop_wr_valid && snoop_slave == 7'h54 && snoop_offset == 8'h20
      && !ddc_training_disable && sink_hot_plug_in && $past(sink_hot_plug_in);
  endsequence
  sequence s_idle_wr;
    clk_en && idle && reg_wr && reg_addr == 8'h0C ##1 clk_en && idle;
  endsequence
  a_hot_plug_gate: assert property (
    clk_en && !sink_hot_plug_in |=> !source_hot_plug_out) else $error("hot-plug leak");
  a_unmapped_read: assert property (
    clk_en && reg_rd && !(reg_addr inside {[8'h0A:8'h0C]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ratio_readback: assert property (
    clk_en && reg_rd && reg_addr == 8'h0B |=> reg_rdata[2:0] ==
    {1'b0, $past(link_clock_ratio_flag), $past(ddc_training_disable)}) else $error("0B read");
  a_snoop_ratio: assert property (
    s_snoop_hit |=> link_clock_ratio_flag == $past(snoop_data[1])) else $error("snoop");
  a_train_force: assert property (
    clk_en && ddc_training_disable |=> link_clock_ratio_flag) else $error("forcing");
  a_hpd_clear: assert property (
    low_cnt_q > HPD_LOW_COUNT + 2 && !ddc_training_disable && !$past(ddc_training_disable)
    |-> !link_clock_ratio_flag) else $error("ratio kept");
  a_idle_apply: assert property (
    s_idle_wr |=> lane_deemphasis == $past(reg_wdata[1:0], 2)) else $error("idle apply");
  a_staged_hold: assert property (
    clk_en && !idle && !commit |=> $stable(lane_deemphasis)) else $error("staged leak");
endmodule : link_regs_checker
bind retimer_link_control_regs link_regs_checker #(.HPD_LOW_COUNT(HPD_LOW_COUNT))
  i_link_regs_checker (.*);
`default_nettype wire

/* testbench/ddc_source_model.sv */
// source-side sideband master model feeding decoded write bytes
`timescale 1ns/1ps
`default_nettype none
module ddc_source_model (
  input  wire logic clk,
  output logic       snoop_wr_valid = 1'b0,
  output logic [6:0] snoop_slave = 7'h00,
  output logic [7:0] snoop_offset = 8'h00,
  output logic [7:0] snoop_data = 8'h00
);
  logic [22:0] q[$];
  // between bytes the lines toggle so no stale value looks valid
  always @(posedge clk)
    if (q.size() != 0) begin
      {snoop_slave, snoop_offset, snoop_data} <= q.pop_front();
      snoop_wr_valid <= 1'b1;
    end else begin
      snoop_wr_valid <= 1'b0;
      {snoop_slave, snoop_offset, snoop_data} <= ~{snoop_slave, snoop_offset, snoop_data};
    end
  task automatic put(input logic [22:0] b);
    @(negedge clk);
    q.push_back(b);
    repeat (2) @(posedge clk);
    #1;
  endtask : put
endmodule : ddc_source_model
`default_nettype wire

/* testbench/retimer_link_control_regs_test.sv */
// self-checking bench for the link control register bank
`timescale 1ns/1ps
`default_nettype none
module retimer_link_control_regs_test;
  import link_ctrl_pkg::*;
  localparam int HPD = 20;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, strap_config = 1, output_enable_in = 0;
  logic sink_hot_plug_in = 0, forced_power_down = 0, snoop_wr_valid, source_hot_plug_out;
  logic clk_en = 1;
  logic app_sink_centre, aux_ddc_bridge_on, dvi_select, ddc_training_disable;
  logic link_clock_ratio_flag, lane_equalizer_adaptive, lane_equalizer_on;
  logic [1:0] strap_termination = 0, function_mode_select, lane_edge_rate, lane_termination;
  logic [1:0] lane_deemphasis;
  logic [2:0] lane_data_swing, lane_clock_swing;
  logic [6:0] snoop_slave;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, snoop_offset, snoop_data, r, d, m[3];
  logic [23:0] sc[5] = '{24'hA84005, 24'hAA4001, 24'hA84201, 24'hA841FA, 24'hA84005};
  logic [31:0] seed = 32'd71956;
  int errors = 0, total_checks = 0, cyc = 0, a;
  retimer_link_control_regs #(.HPD_LOW_COUNT(HPD)) i_retimer_link_control_regs (.*);
  ddc_source_model i_ddc_source_model (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 0;
    tick(1);
    r = reg_rdata;
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    m = '{8'h39, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) begin
      rd(8'(10 + i));
      chk(r, m[i]);
    end
    rd(8'h0D);
    chk(r, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = i % 3;
      d = (a == 0) ? {seed[7:2], i[1:0]} : seed[7:0] & ((a == 1) ? 8'hE8 : 8'hFF);
      wr(8'(10 + a), d);
      m[a] = d & ((a == 0) ? 8'hFB : 8'hFF);
      rd(8'(10 + a));
      chk(r, m[a]);
      chk({app_sink_centre, aux_ddc_bridge_on, function_mode_select, lane_equalizer_adaptive,
           lane_equalizer_on, 2'b00}, {m[0][7], m[0][3], m[0][1:0], m[0][5:4], 2'b00});
      chk({lane_data_swing, lane_clock_swing, lane_deemphasis}, m[2]);
      chk({lane_edge_rate, dvi_select, lane_termination, 3'b000}, m[1]);
    end
    wr(8'h0A, 8'h3A);
    forced_power_down <= 1;
    tick(1);
    forced_power_down <= 0;
    $display("test random access done");
    strap_config <= 0;
    strap_termination <= 2'b11;
    sink_hot_plug_in <= 1;
    wr(8'h0A, 8'hC0);
    wr(8'h0B, 8'h30);
    m[0] = 8'hE0;
    m[1] = {m[1][7:5], 5'b11000};
    for (int i = 0; i < 2; i++) begin
      rd(8'(10 + i));
      chk(r, m[i]);
    end
    chk(8'(source_hot_plug_out), 8'h00);
    strap_config <= 1;
    wr(8'h0A, 8'h39);
    m[0] = 8'h39;
    tick(2);
    chk(8'(source_hot_plug_out), 8'h01);
    $display("test strap and hot-plug done");
    output_enable_in <= 1;
    wr(8'h0C, 8'h25);
    tick(2);
    chk({lane_data_swing, lane_clock_swing, lane_deemphasis}, m[2]);
    wr(8'h0A, 8'h3D);
    tick(1);
    chk({lane_data_swing, lane_clock_swing, lane_deemphasis}, 8'h25);
    rd(8'h0A);
    chk(r, m[0]);
    clk_en <= 0;
    wr(8'h0C, 8'h5A);
    clk_en <= 1;
    rd(8'h0C);
    chk(r, 8'h25);
    $display("test staged lanes done");
    foreach (sc[j]) begin
      i_ddc_source_model.put(sc[j][23:1]);
      chk(8'(link_clock_ratio_flag), 8'(sc[j][0]));
    end
    rd(8'h0B);
    chk(r, m[1] | 8'h02);
    sink_hot_plug_in <= 0;
    tick(HPD + 4);
    chk(8'(link_clock_ratio_flag), 8'h00);
    sink_hot_plug_in <= 1;
    m[1] = m[1] | 8'h01;
    wr(8'h0B, m[1]);
    tick(2);
    rd(8'h0B);
    chk(r, m[1] | 8'h02);
    $display("test ratio flag done");
    wrap_up();
  end
endmodule : retimer_link_control_regs_test
`default_nettype wire
